// *** logic/halt_log_mem.sv ***
/*
  Small memory of past halt codes, registered read data.
  Assumes one clock; the memory itself has no reset.
*/
`timescale 1ns/1ps
`default_nettype none
module halt_log_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  input  wire logic                     mclk,   // system clock
  input  wire logic                     wr_en,  // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr,  // write address
  input  wire logic [WIDTH-1:0]         wdata,  // write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr,  // read address
  output logic      [WIDTH-1:0]         rdata   // registered read data
);
  logic [WIDTH-1:0] store [DEPTH];

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("halt_log_mem: DEPTH must be a power of two");
  end

  always_ff @(posedge mclk) begin
    if (wr_en)
      store[waddr] <= wdata;
    rdata <= store[raddr];
  end
endmodule
`default_nettype wire

// *** logic/vector_and_halt_code_unit.sv ***
/*
  Exception vector, priority and halt code dispatch, plus coarse physical
  address window decode, with an Avalon-MM register slave.
  Assumes adapter requests and core strobes are on mclk; the console halt
  pin is asynchronous and is synchronised here.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "vhcu_regs.svh"
module vector_and_halt_code_unit
  import vhcu_pkg::*;
#(
  parameter int LOG_DEPTH = 16
) (
  input  wire logic        mclk,                       // 50 MHz clock
  input  wire logic        rstn,                       // sync reset, low
  input  wire logic [4:0]  avs_address,                // byte address
  input  wire logic        avs_read,                   // read request
  input  wire logic        avs_write,                  // write request
  input  wire logic [31:0] avs_writedata,              // write data
  output logic      [31:0] avs_readdata,               // read data
  output logic             avs_waitrequest,            // stall
  output logic             irq,                        // level interrupt
  input  wire logic [63:0] adapter0_request,           // level*16+nexus
  input  wire logic [63:0] adapter1_request,           // level*16+nexus
  input  wire logic        dispatch_ready,             // core takes intr
  input  wire logic        mcheck_event,               // machine check
  input  wire logic        mcheck_unrelated,           // not this instr
  input  wire logic        mcheck_done,                // initiation over
  input  wire logic        console_microcode_running,  // level
  input  wire logic        interrupt_stack_invalid,    // during initiation
  input  wire logic        halt_kernel_exec,           // halt instr kernel
  input  wire logic        error_pending,              // error outstanding
  input  wire logic        vector_fetch,               // vector read strobe
  input  wire logic [1:0]  vector_low,                 // vector bits 1:0
  input  wire logic        change_mode_exec,           // change mode strobe
  input  wire logic        interrupt_stack_flag,       // stack flag
  input  wire logic [1:0]  change_mode_vector_low,     // its vector bits
  input  wire logic        console_halt_pin,           // async operator halt
  input  wire logic [31:0] phys_addr,                  // address to decode
  output logic             dispatch_valid,             // one-cycle pulse
  output logic      [15:0] dispatch_vector,            // vector offset
  output logic      [4:0]  dispatch_ipl,               // priority level
  output logic             exec_stop,                  // execution halted
  output logic             halt_valid,                 // one-cycle pulse
  output halt_code_t       halt_code,                  // latched code
  output region_t          addr_region,                // decoded window
  output logic      [1:0]  addr_bus_index              // peripheral bus
);
  localparam int LW = $clog2(LOG_DEPTH);

  if (LOG_DEPTH < 2 || LOG_DEPTH > 256) begin
    $error("vector_and_halt_code_unit: LOG_DEPTH out of range");
  end

  // bus slave: every access waits exactly one cycle
  logic                 ack;
  logic [31:0]          control;
  logic [`ST_WIDTH-1:0] status;
  logic [`ST_WIDTH-1:0] mask;
  logic [LW-1:0]        log_index;
  logic [LW-1:0]        log_wptr;
  logic [7:0]           log_rdata;

  wire       access  = avs_read | avs_write;
  wire       done    = access & ack;
  wire       wr_done = avs_write & ack;
  wire       rd_done = avs_read & ack;
  wire [2:0] word    = avs_address[4:2];
  wire       wr_ctl  = wr_done & (avs_address == `OFS_CONTROL);
  wire       wr_mask = wr_done & (avs_address == `OFS_MASK);
  wire       wr_idx  = wr_done & (avs_address == `OFS_LOG_INDEX);
  wire       rd_stat = rd_done & (avs_address == `OFS_STATUS);

  assign avs_waitrequest = access & ~ack;

  always_ff @(posedge mclk) begin
    if (!rstn)
      ack <= 1'b0;
    else
      ack <= access & ~ack;
  end

  wire       dispatch_enable = control[`CTL_ENABLE];
  wire       wcs_loaded      = control[`CTL_WCS];
  wire [4:0] cpu_level       = control[`CTL_LEVEL_HI:`CTL_LEVEL_LO];
  wire       resume          = wr_ctl & avs_writedata[`CTL_RESUME];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      control   <= `CTL_RESET;
      mask      <= `MASK_RESET;
      log_index <= '0;
    end else begin
      if (wr_ctl)
        control <= avs_writedata & ~(32'h1 << `CTL_RESUME);
      if (wr_mask)
        mask <= avs_writedata[`ST_WIDTH-1:0];
      if (wr_idx)
        log_index <= avs_writedata[LW-1:0];
    end
  end

  // console halt pin: three flops, accepted when second and third agree
  logic sync1;
  logic sync2;
  logic sync3;
  logic console_level;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1         <= 1'b0;
      sync2         <= 1'b0;
      sync3         <= 1'b0;
      console_level <= 1'b0;
    end else begin
      sync1 <= console_halt_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        console_level <= sync3;
    end
  end

  wire console_rise = (sync2 == sync3) & sync3 & ~console_level;

  // halt detection, fixed priority among simultaneous causes
  logic halted;
  logic mcheck_active;

  wire c_hang  = ~console_microcode_running;                           // [RL4]
  wire c_istk  = interrupt_stack_invalid;                              // [RL5]
  wire c_dbl   = mcheck_event & mcheck_active;                         // [RL6]
  wire c_kern  = halt_kernel_exec;                                     // [RL7]
  wire c_vec3  = vector_fetch & (vector_low == 2'b11);                 // [RL8]
  wire c_vec2  = vector_fetch & (vector_low == 2'b10) & ~wcs_loaded;   // [RL8]
  wire c_pend  = halt_kernel_exec & error_pending;                     // [RL9]
  wire c_chmis = change_mode_exec & interrupt_stack_flag;              // [RL10]
  wire c_chmv  = change_mode_exec & (|change_mode_vector_low);         // [RL11]
  wire c_cons  = console_rise;                                         // [RL12]

  wire any_cause = c_hang | c_istk | c_dbl | c_kern | c_vec3 | c_vec2
                 | c_chmis | c_chmv | c_cons;
  wire halt_now  = any_cause & ~halted;

  wire [7:0] next_code =
      c_hang  ? `HALT_HANG    :
      c_dbl   ? `HALT_DOUBLE  :
      c_istk  ? `HALT_ISTACK  :
      c_vec3  ? `HALT_VEC3    :
      c_vec2  ? `HALT_VEC2    :
      c_chmis ? `HALT_CHM_IS  :
      c_chmv  ? `HALT_CHM_VEC :
      c_pend  ? `HALT_PENDING :
      c_kern  ? `HALT_KERNEL  :
                `HALT_CONSOLE;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      halted     <= 1'b0;
      halt_valid <= 1'b0;
      halt_code  <= `HALT_HANG;
    end else begin
      halt_valid <= halt_now;                                          // [RL15]
      if (halt_now) begin
        halted    <= 1'b1;                                             // [RL15]
        halt_code <= next_code;                                        // [RL15]
      end else if (resume) begin
        halted <= 1'b0;
      end
    end
  end

  assign exec_stop = halted;

  always_ff @(posedge mclk) begin
    if (!rstn)
      log_wptr <= '0;
    else if (halt_now)
      log_wptr <= log_wptr + 1'b1;
  end

  halt_log_mem #(
    .DEPTH (LOG_DEPTH),
    .WIDTH (8)
  ) u_log (
    .mclk  (mclk),
    .wr_en (halt_now),
    .waddr (log_wptr),
    .wdata (next_code),
    .raddr (log_index),
    .rdata (log_rdata)
  );

  // interrupt arbitration: later loop passes override earlier ones
  logic        win_found;
  logic [1:0]  win_level;
  logic        win_adapter;
  logic [3:0]  win_nexus;

  always_comb begin
    win_found   = 1'b0;
    win_level   = 2'd0;
    win_adapter = 1'b0;
    win_nexus   = 4'd0;
    for (int lv = 0; lv < 4; lv++) begin
      for (int a = 1; a >= 0; a--) begin
        for (int n = 15; n >= 0; n--) begin
          if ((a == 0 ? adapter0_request[lv*16+n] : adapter1_request[lv*16+n])
              && ({`IPL_LEVEL_BASE, 2'(lv)} > cpu_level)) begin   // [RL16]
            win_found   = 1'b1;
            win_level   = 2'(lv);
            win_adapter = 1'(a);
            win_nexus   = 4'(n);
          end
        end
      end
    end
  end

  wire [15:0] intr_base   = win_adapter ? `VEC_ADAPTER1 : `VEC_ADAPTER0; // [RL2] [RL3]
  wire [15:0] intr_vector = intr_base | {8'h00, win_level, win_nexus, 2'b00};
  wire [4:0]  intr_ipl    = {`IPL_LEVEL_BASE, win_level};             // [RL2] [RL3]
  wire        mcheck_go   = mcheck_event & ~mcheck_active & ~halt_now & ~halted;
  wire        intr_go     = win_found & dispatch_ready & dispatch_enable
                          & ~halted & ~halt_now & ~mcheck_event & ~dispatch_valid;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dispatch_valid  <= 1'b0;
      dispatch_vector <= 16'h0000;
      dispatch_ipl    <= 5'h00;
      mcheck_active   <= 1'b0;
    end else begin
      dispatch_valid <= mcheck_go | intr_go;
      if (mcheck_go) begin
        dispatch_vector <= `VEC_MCHECK;                                // [RL1]
        dispatch_ipl    <= mcheck_unrelated ? `IPL_MCHECK_LOW : `IPL_MCHECK; // [RL1]
      end else if (intr_go) begin
        dispatch_vector <= intr_vector;
        dispatch_ipl    <= intr_ipl;
      end
      if (mcheck_go)
        mcheck_active <= 1'b1;
      else if (mcheck_done || resume)
        mcheck_active <= 1'b0;
    end
  end

  // sticky status, set wins over the read clear
  wire [`ST_WIDTH-1:0] events = {c_dbl & ~halted, intr_go, mcheck_go, halt_now};

  always_ff @(posedge mclk) begin
    if (!rstn)
      status <= '0;
    else
      status <= (rd_stat ? '0 : status) | events;
  end

  assign irq = |(status & mask);

  // address windows
  wire in_bus = (phys_addr >= `ADDR_BUS_LO) && (phys_addr <= `ADDR_BUS_HI);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr_region    <= REGION_OTHER;
      addr_bus_index <= 2'd0;
    end else begin
      addr_bus_index <= in_bus ? phys_addr[19:18] : 2'd0;              // [RL13]
      if (phys_addr >= `ADDR_RESERVED)
        addr_region <= REGION_RESERVED;                                // [RL14]
      else if (phys_addr >= `ADDR_ADAPTER3)
        addr_region <= REGION_ADAPTER3;                                // [RL14]
      else if (phys_addr >= `ADDR_ADAPTER2)
        addr_region <= REGION_ADAPTER2;                                // [RL14]
      else if (in_bus)
        addr_region <= REGION_PERIPH_BUS;                              // [RL13]
      else
        addr_region <= REGION_OTHER;
    end
  end

  // read data is latched in the wait cycle and stands in the answer cycle
  logic [31:0] read_mux;

  always_comb begin
    unique case (word)
      3'd0:    read_mux = {28'h0, status};
      3'd1:    read_mux = {28'h0, mask};
      3'd2:    read_mux = control;
      3'd3:    read_mux = {23'h0, halted, halt_code};
      3'd4:    read_mux = {11'h0, dispatch_ipl, dispatch_vector};
      3'd5:    read_mux = 32'(log_index);
      3'd6:    read_mux = {24'h0, log_rdata};
      default: read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack)
      avs_readdata <= read_mux;
  end
endmodule
`default_nettype wire

// *** logic/vhcu_pkg.sv ***
/*
  Types shared by the vector and halt code unit.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package vhcu_pkg;
  typedef enum logic [2:0] {
    REGION_OTHER,
    REGION_PERIPH_BUS,
    REGION_ADAPTER2,
    REGION_ADAPTER3,
    REGION_RESERVED
  } region_t;
  typedef logic [7:0] halt_code_t;
endpackage
`default_nettype wire

// *** logic/vhcu_regs.svh ***
/*
  Register offsets, field positions, reset values, vector and halt-code
  constants for the vector and halt code unit.
  Assumes byte addressing on the register bus, one aligned word per register.
*/
// Operation
// RL1 - machine check goes to vector 04 at level 1F, or 1D if unrelated
// RL2 - adapter 0 nexus requests levels 4-7 map to 100-1FC, levels 14-17
// RL3 - adapter 1 nexus requests levels 4-7 map to 300-3FC, levels 14-17
// RL4 - halt code 0 when console-support microcode is not running
// RL5 - halt code 4 when interrupt stack invalid during initiation
// RL6 - halt code 5 on a second machine check during machine check initiation
// RL7 - halt code 6 on halt instruction in kernel mode
// RL8 - halt code 7 for vector low bits 3; code 8 for 2 without control store
// RL9 - halt code 9 when an error is pending at halt
// RL10 - halt code A on change-mode instruction with interrupt stack flag set
// RL11 - halt code B on change-mode instruction with nonzero vector low bits
// RL12 - halt code 11 when the operator halts from the console
// RL13 - decode 2010 0000 to 201F FFFF as peripheral buses 0-3 of adapter 0
// RL14 - decode 2400/2600 0000 as adapters 2 and 3, 2800 0000 up reserved
// RL15 - any halt stops execution and presents the code to the console
// RL16 - only the highest pending level above the current level is serviced
`ifndef VHCU_REGS_SVH
`define VHCU_REGS_SVH

`define OFS_STATUS        5'h00
`define OFS_MASK          5'h04
`define OFS_CONTROL       5'h08
`define OFS_HALT          5'h0C
`define OFS_DISPATCH      5'h10
`define OFS_LOG_INDEX     5'h14
`define OFS_LOG_DATA      5'h18

`define ST_HALT           0
`define ST_MCHECK         1
`define ST_INTR           2
`define ST_DOUBLE         3
`define ST_WIDTH          4

`define CTL_ENABLE        0
`define CTL_WCS           1
`define CTL_RESUME        2
`define CTL_LEVEL_LO      8
`define CTL_LEVEL_HI      12
`define CTL_RESET         32'h00000001
`define MASK_RESET        4'h0

`define VEC_MCHECK        16'h0004
`define VEC_ADAPTER0      16'h0100
`define VEC_ADAPTER1      16'h0300
`define IPL_MCHECK        5'h1F
`define IPL_MCHECK_LOW    5'h1D
`define IPL_LEVEL_BASE    3'h5

`define HALT_HANG         8'h00
`define HALT_ISTACK       8'h04
`define HALT_DOUBLE       8'h05
`define HALT_KERNEL       8'h06
`define HALT_VEC3         8'h07
`define HALT_VEC2         8'h08
`define HALT_PENDING      8'h09
`define HALT_CHM_IS       8'h0A
`define HALT_CHM_VEC      8'h0B
`define HALT_CONSOLE      8'h11

`define ADDR_BUS_LO       32'h20100000
`define ADDR_BUS_HI       32'h201FFFFF
`define ADDR_ADAPTER2     32'h24000000
`define ADDR_ADAPTER3     32'h26000000
`define ADDR_RESERVED     32'h28000000

`endif

// *** verification/adapter_model.sv ***
/*
  Model of the two system bus adapters raising nexus requests.
  Assumes the bench posts requests as one-cycle masks.
*/
`timescale 1ns/1ps
`default_nettype none
module adapter_model (
  input  wire logic        mclk,              // clock
  input  wire logic        rstn,              // reset
  input  wire logic [63:0] post0,             // new adapter 0 requests
  input  wire logic [63:0] post1,             // new adapter 1 requests
  input  wire logic        dispatch_valid,    // unit served one
  input  wire logic [15:0] dispatch_vector,   // served vector
  output logic      [63:0] adapter0_request,  // held requests
  output logic      [63:0] adapter1_request   // held requests
);
  logic [63:0] served;
  // a request is held until the unit dispatches its vector
  assign served = (dispatch_valid && dispatch_vector[15:8] != 8'h00) ?
                  64'h1 << dispatch_vector[7:2] : 64'h0;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      adapter0_request <= '0;
      adapter1_request <= '0;
    end else begin
      adapter0_request <= (adapter0_request | post0) & ~(dispatch_vector[9] ? '0 : served);
      adapter1_request <= (adapter1_request | post1) & ~(dispatch_vector[9] ? served : '0);
    end
  end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/*
  Self-checking bench for the vector and halt code unit.
  Assumes the unit, its checker and the adapter model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vhcu_regs.svh"
module tb
  import vhcu_pkg::*;
;
  logic        mclk = '0, rstn = '0, avs_read = '0, avs_write = '0, dispatch_ready = 1'h1;
  logic        mcheck_event = '0, mcheck_unrelated = '0, mcheck_done = '0;
  logic        console_microcode_running = 1'h1, interrupt_stack_invalid = '0;
  logic        halt_kernel_exec = '0, error_pending = '0, vector_fetch = '0;
  logic        change_mode_exec = '0, interrupt_stack_flag = '0, console_halt_pin = '0;
  logic        avs_waitrequest, irq, dispatch_valid, exec_stop, halt_valid;
  logic [1:0]  vector_low = '0, change_mode_vector_low = '0, addr_bus_index;
  logic [4:0]  avs_address = '0, dispatch_ipl;
  logic [15:0] dispatch_vector;
  logic [31:0] avs_writedata = '0, phys_addr = '0, avs_readdata, q;
  logic [63:0] adapter0_request, adapter1_request, post0 = '0, post1 = '0;
  halt_code_t  halt_code;
  region_t     addr_region;
  int          n_mismatch = 0, total_checks = 0;

  vector_and_halt_code_unit vector_and_halt_code_unit_i (.*);
  adapter_model adapter_model_i (.mclk, .rstn, .post0, .post1, .dispatch_valid,
                                 .dispatch_vector, .adapter0_request, .adapter1_request);

  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one register access; q holds read data taken at the accepting edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    chk("bus answer", 32'h1, {31'h0, n < 20});
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  task automatic wait_ev(input logic disp);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((disp ? dispatch_valid : halt_valid) !== 1'h1 && n < 10);
    chk(disp ? "dispatch_valid" : "halt_valid", 32'h1, {31'h0, n < 10});
  endtask

  task automatic t_reset();
    logic [4:0]  ra [4] = '{`OFS_CONTROL, `OFS_MASK, 5'h1C, `OFS_HALT};
    logic [31:0] rv [4] = '{`CTL_RESET, 32'h0, 32'h0, 32'h0};
    bus(1'h1, 5'h1C, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      bus(1'h0, ra[i], '0);
      chk("register", rv[i], q);
    end
    $display("reset test done");
  endtask

  task automatic t_decode();
    logic [31:0] da [8] = '{32'h2010_0000, 32'h2014_0000, 32'h201F_FFFF, 32'h2020_0000,
                            32'h2400_0000, 32'h2600_0000, 32'h27FF_FFFF, 32'h2800_0000};
    logic [4:0]  dx [8] = '{5'h04, 5'h05, 5'h07, 5'h00, 5'h08, 5'h0C, 5'h0C, 5'h10};
    foreach (da[i]) begin
      @(posedge mclk);
      phys_addr <= da[i];
      @(posedge mclk);
      @(negedge mclk);
      chk("region", dx[i], {addr_region, addr_bus_index});
    end
    $display("decode test done");
  endtask

  task automatic post(input logic [63:0] m0, input logic [63:0] m1);
    @(posedge mclk);
    post0 <= m0;
    post1 <= m1;
    @(posedge mclk);
    post0 <= '0;
    post1 <= '0;
  endtask

  task automatic t_intr();
    logic [31:0] ev [3] = '{32'h1E4, 32'h3C8, 32'h154};
    logic [31:0] el [3] = '{32'h17, 32'h17, 32'h15};
    // nexus 5*level walks nexus 0 to 15 across the four levels
    for (int a = 0; a < 2; a++) begin
      for (int l = 0; l < 4; l++) begin
        post(a ? '0 : 64'h1 << (l * 21), a ? 64'h1 << (l * 21) : '0);
        wait_ev(1'h1);
        chk("vector", (a ? 32'h300 : 32'h100) + l * 32'h54, dispatch_vector);
        chk("level", 32'h14 + l, dispatch_ipl);
      end
    end
    post(64'h1 << 57 | 64'h1 << 21, 64'h1 << 50);
    dispatch_ready <= 1'h0;
    repeat (3) @(negedge mclk);
    chk("dispatch held", 32'h0, dispatch_valid);
    @(posedge mclk);
    dispatch_ready <= 1'h1;
    foreach (ev[i]) begin
      wait_ev(1'h1);
      chk("vector", ev[i], dispatch_vector);
      chk("level", el[i], dispatch_ipl);
    end
    $display("interrupt test done");
  endtask

  task automatic t_mcheck();
    for (int u = 1; u >= 0; u--) begin
      @(posedge mclk);
      mcheck_event <= 1'h1;
      mcheck_unrelated <= u[0];
      @(posedge mclk);
      mcheck_event <= 1'h0;
      wait_ev(1'h1);
      chk("mcheck vector", 32'h4, dispatch_vector);
      chk("mcheck level", u ? 32'h1D : 32'h1F, dispatch_ipl);
      @(posedge mclk);
      mcheck_done <= u[0];
      @(posedge mclk);
      mcheck_done <= 1'h0;
    end
    $display("machine check test done");
  endtask

  // case 0 is a second machine check while the last one is still open
  task automatic t_halts();
    halt_code_t hc [10] = '{8'h05, 8'h00, 8'h04, 8'h06, 8'h09, 8'h07, 8'h08, 8'h0A, 8'h0B,
                            8'h11};
    for (int k = 0; k < 10; k++) begin
      if (k == 1) bus(1'h1, `OFS_MASK, 32'h1);
      @(posedge mclk);
      case (k)
        0: mcheck_event <= 1'h1;
        1: console_microcode_running <= 1'h0;
        2: interrupt_stack_invalid <= 1'h1;
        3, 4: begin
          halt_kernel_exec <= 1'h1;
          error_pending <= k == 4;
        end
        5, 6: begin
          vector_fetch <= 1'h1;
          vector_low <= (k == 5) ? 2'h3 : 2'h2;
        end
        7, 8: begin
          change_mode_exec <= 1'h1;
          interrupt_stack_flag <= k == 7;
          change_mode_vector_low <= (k == 8) ? 2'h1 : 2'h0;
        end
        default: console_halt_pin <= 1'h1;
      endcase
      @(posedge mclk);
      mcheck_event <= 1'h0;
      console_microcode_running <= 1'h1;
      interrupt_stack_invalid <= 1'h0;
      halt_kernel_exec <= 1'h0;
      error_pending <= 1'h0;
      vector_fetch <= 1'h0;
      change_mode_exec <= 1'h0;
      interrupt_stack_flag <= 1'h0;
      change_mode_vector_low <= 2'h0;
      wait_ev(1'h0);
      chk("halt_code", hc[k], halt_code);
      chk("exec_stop", 32'h1, exec_stop);
      chk("irq", k != 0, irq);
      bus(1'h0, `OFS_STATUS, '0);
      console_halt_pin <= 1'h0;
      chk("status halt", 32'h1, q[0]);
      @(negedge mclk);
      chk("irq cleared", 32'h0, irq);
      bus(1'h1, `OFS_CONTROL, 32'h5);
      @(negedge mclk);
      chk("exec_stop", 32'h0, exec_stop);
    end
    bus(1'h1, `OFS_LOG_INDEX, 32'h9);
    bus(1'h0, `OFS_LOG_DATA, '0);
    chk("halt log", 32'h11, q);
    $display("halt test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    t_reset();
    t_decode();
    t_intr();
    t_mcheck();
    t_halts();
    end_of_test();
  end

  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire

// *** verification/vhcu_asserts.sv ***
/*
  Assertion checker for the vector and halt code unit.
  Assumes it is bound into the unit and reads only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module vhcu_asserts
  import vhcu_pkg::*;
(
  input wire logic        mclk,                       // clock
  input wire logic        rstn,                       // reset
  input wire logic        mcheck_event,               // in
  input wire logic        mcheck_unrelated,           // in
  input wire logic        console_microcode_running,  // in
  input wire logic        interrupt_stack_invalid,    // in
  input wire logic        halt_kernel_exec,           // in
  input wire logic        error_pending,              // in
  input wire logic        vector_fetch,               // in
  input wire logic [1:0]  vector_low,                 // in
  input wire logic        change_mode_exec,           // in
  input wire logic        interrupt_stack_flag,       // in
  input wire logic [1:0]  change_mode_vector_low,     // in
  input wire logic [31:0] phys_addr,                  // in
  input wire logic        dispatch_valid,             // out
  input wire logic [15:0] dispatch_vector,            // out
  input wire logic [4:0]  dispatch_ipl,               // out
  input wire logic        exec_stop,                  // out
  input wire logic        halt_valid,                 // out
  input wire halt_code_t  halt_code,                  // out
  input wire region_t     addr_region,                // out
  input wire logic [1:0]  addr_bus_index              // out
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // calm: no higher-priority halt cause is present
  logic    calm;
  region_t exp_region;
  logic    periph;
  logic [1:0] exp_index;
  assign calm = console_microcode_running && !mcheck_event && !exec_stop
                && !interrupt_stack_invalid;
  assign periph = phys_addr[31:20] == 12'h201;
  assign exp_index = periph ? phys_addr[19:18] : 2'h0;
  assign exp_region = periph ? REGION_PERIPH_BUS :
                      (phys_addr[31:25] == 7'h12) ? REGION_ADAPTER2 :
                      (phys_addr[31:25] == 7'h13) ? REGION_ADAPTER3 :
                      (phys_addr >= 32'h2800_0000) ? REGION_RESERVED : REGION_OTHER;

  AST_MCHK_LEVEL: assert property (
    dispatch_valid && dispatch_vector == 16'h0004 |->
    dispatch_ipl == ($past(mcheck_unrelated) ? 5'h1D : 5'h1F)) else $error("mcheck level");
  AST_INTR_VEC: assert property (
    dispatch_valid && dispatch_vector != 16'h0004 |-> dispatch_vector[15:10] == 6'h00
    && dispatch_vector[8] && dispatch_vector[1:0] == 2'h0
    && dispatch_ipl == 5'h14 + dispatch_vector[7:6]) else $error("intr vector");
  AST_HANG: assert property (
    !console_microcode_running && !exec_stop |=> halt_valid && halt_code == 8'h00)
    else $error("hang code");
  AST_ISTACK: assert property (
    console_microcode_running && !mcheck_event && !exec_stop && interrupt_stack_invalid
    |=> halt_valid && halt_code == 8'h04) else $error("istack code");
  AST_KERNEL: assert property (
    calm && !vector_fetch && !change_mode_exec && halt_kernel_exec |=> halt_valid
    && halt_code == ($past(error_pending) ? 8'h09 : 8'h06)) else $error("kernel code");
  AST_VEC3: assert property (
    calm && vector_fetch && vector_low == 2'h3 |=> halt_valid && halt_code == 8'h07)
    else $error("vector code");
  AST_CHM: assert property (
    calm && !vector_fetch && change_mode_exec
    && (interrupt_stack_flag || change_mode_vector_low != 2'h0) |=> halt_valid
    && halt_code == ($past(interrupt_stack_flag) ? 8'h0A : 8'h0B)) else $error("chm code");
  AST_HALT_PULSE: assert property (
    halt_valid |-> exec_stop ##1 !halt_valid) else $error("halt pulse");
  AST_STOP_HOLD: assert property (
    exec_stop && $past(exec_stop) |-> $stable(halt_code) && !halt_valid)
    else $error("halt hold");
  AST_DECODE: assert property (
    $past(rstn) |-> addr_region == $past(exp_region)
    && addr_bus_index == $past(exp_index)) else $error("decode");

  COV_ADAPTER1: cover property (dispatch_valid && dispatch_vector[9]);
  COV_DOUBLE: cover property (halt_valid && halt_code == 8'h05);
  COV_CONSOLE: cover property (halt_valid && halt_code == 8'h11);
endmodule
bind vector_and_halt_code_unit vhcu_asserts vhcu_asserts_i (.*);
`default_nettype wire
